// ---- src/ptt_regs.svh ----
`ifndef PTT_REGS_SVH
`define PTT_REGS_SVH

// Register byte offset
`define PTT_CTRL_OFFSET   12'h000

// Control register fields
`define PTT_FLAG_BIT      7
`define PTT_RATE_MSB      6
`define PTT_RATE_LSB      4
`define PTT_ACK_BIT       3
`define PTT_IE_BIT        2
`define PTT_RUN_BIT       1
`define PTT_CTRL_RESET    8'h00

// Divider chain
`define PTT_DIV_STAGES    15

// Tap bit per rate code; a rising tap bit gives one tick per divide ratio
`define PTT_TAP_32768     4'hE
`define PTT_TAP_8192      4'hC
`define PTT_TAP_2048      4'hA
`define PTT_TAP_128       4'h6
`define PTT_TAP_64        4'h5
`define PTT_TAP_32        4'h4
`define PTT_TAP_16        4'h3
`define PTT_TAP_8         4'h2

`endif

// ---- src/ptt_pkg.sv ----
package ptt_pkg;

    typedef logic [2:0] ptt_rate_t;
    typedef logic [3:0] ptt_tap_t;
    typedef logic [7:0] ptt_ctrl_t;

endpackage

// ---- src/ptt_timebase.sv ----
// Overview of operation
// - Divider ticks from external clock when its generator is on, else internal clock.
// - Divider is fifteen stages with eight selectable tap points.
// - Rate codes 0..7 select divide 32768, 8192, 2048, 128, 64, 32, 16, 8.
// - Divider counter is held at zero while run enable is clear.
// - Divider advances on tick source edges once run enable is set.
// - Tick flag sets each time the selected tap overflows.
// - Interrupt request is raised when tick flag and interrupt enable are set.
// - First flag after enable comes at half period, later ones every period.
// - Tick flag is read only; writes to its bit do nothing.
// - Writing one to acknowledge clears the flag; zero no effect; reads zero.
// - Interrupt enable resets to zero and is read/write.
// - Run enable resets to zero; clearing then setting restarts from zero.
// - Divider keeps counting and flagging in wait mode.
// - Control register is not accessible during wait or stop mode.
// - In stop mode the block runs only when oscillator runs in stop.
// - Without oscillator in stop, the block is inactive throughout stop mode.
`timescale 1ns/1ps
`include "ptt_regs.svh"

module ptt_timebase #(
    parameter int DIV_STAGES = `PTT_DIV_STAGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_clock_in,
    input  wire logic        internal_osc_clock,
    input  wire logic        ext_clock_gen_on,
    input  wire logic        osc_run_in_stop,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic             tick_irq
);

    logic [1:0]            ext_sync_reg;
    logic [1:0]            int_sync_reg;
    logic                  src_prev_reg;
    logic                  src_level;
    logic                  src_edge;
    logic                  active;
    logic [DIV_STAGES-1:0] cnt_reg;
    logic [DIV_STAGES-1:0] cnt_next;
    logic [DIV_STAGES-1:0] tap_onehot;
    logic [DIV_STAGES-1:0] tap_low_mask;
    ptt_pkg::ptt_tap_t     tap_sel;
    logic                  overflow;
    logic                  tick_flag_reg;
    logic                  tick_flag_next;
    logic                  tick_irq_enable_reg;
    logic                  tick_run_enable_reg;
    ptt_pkg::ptt_rate_t    tick_rate_select_reg;
    logic                  access;
    logic                  hit;
    logic                  locked;
    logic                  wr_ok;
    logic                  ack_wr;
    ptt_pkg::ptt_ctrl_t    ctrl_view;

    // Tick sources are foreign clocks, sampled as levels through two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_sync_reg <= 2'h0;
            int_sync_reg <= 2'h0;
        end
        else
        begin
            ext_sync_reg <= {ext_sync_reg[0], external_clock_in};
            int_sync_reg <= {int_sync_reg[0], internal_osc_clock};
        end
    end

    // Selection follows the generator enable, not the bus clock origin
    assign src_level = ext_clock_gen_on ? ext_sync_reg[1] : int_sync_reg[1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            src_prev_reg <= 1'b0;
        else
            src_prev_reg <= src_level;
    end

    // A source switch can yield one extra edge; rate changes are made with the divider off
    assign src_edge = src_level & ~src_prev_reg;

    // Stop mode freezes the chain unless the oscillator keeps running
    assign active = ~stop_mode | osc_run_in_stop;

    always_comb
    begin
        unique case (tick_rate_select_reg)
            3'h0:    tap_sel = `PTT_TAP_32768;
            3'h1:    tap_sel = `PTT_TAP_8192;
            3'h2:    tap_sel = `PTT_TAP_2048;
            3'h3:    tap_sel = `PTT_TAP_128;
            3'h4:    tap_sel = `PTT_TAP_64;
            3'h5:    tap_sel = `PTT_TAP_32;
            3'h6:    tap_sel = `PTT_TAP_16;
            3'h7:    tap_sel = `PTT_TAP_8;
        endcase
    end

    assign tap_onehot   = DIV_STAGES'(1) << tap_sel;
    assign tap_low_mask = tap_onehot - DIV_STAGES'(1);
    assign cnt_next     = cnt_reg + DIV_STAGES'(1);

    // Rising tap bit: first at half the ratio, then once per full ratio
    assign overflow = tick_run_enable_reg & active & src_edge
                      & ~|(cnt_reg & tap_onehot) & |(cnt_next & tap_onehot);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else if (!tick_run_enable_reg)
            cnt_reg <= '0;
        else if (active && src_edge)
            cnt_reg <= cnt_next;
    end

    // APB decode; zero-wait slave, errors on unmapped or low-power access
    assign access = psel & penable;
    assign hit    = paddr == `PTT_CTRL_OFFSET;
    assign locked = wait_mode | stop_mode;
    assign wr_ok  = access & pwrite & hit & ~locked;
    assign ack_wr = wr_ok & pwdata[`PTT_ACK_BIT];
    assign pready = 1'b1;

    assign ctrl_view = {tick_flag_reg, tick_rate_select_reg, 1'b0,
                        tick_irq_enable_reg, tick_run_enable_reg, 1'b0};

    // Set beats acknowledge so a tick in the clearing cycle survives
    assign tick_flag_next = overflow | (tick_flag_reg & ~ack_wr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_flag_reg <= 1'b0;
        else
            tick_flag_reg <= tick_flag_next;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_irq_enable_reg <= 1'(`PTT_CTRL_RESET >> `PTT_IE_BIT);
        else if (wr_ok)
            tick_irq_enable_reg <= pwdata[`PTT_IE_BIT];
    end

    // Clearing run also zeroes the divider, which is how software restarts it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_run_enable_reg <= 1'(`PTT_CTRL_RESET >> `PTT_RUN_BIT);
        else if (wr_ok)
            tick_run_enable_reg <= pwdata[`PTT_RUN_BIT];
    end

    // Rate is taken as written even while running; software keeps it still then
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_rate_select_reg <= 3'(`PTT_CTRL_RESET >> `PTT_RATE_LSB);
        else if (wr_ok)
            tick_rate_select_reg <= pwdata[`PTT_RATE_MSB:`PTT_RATE_LSB];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                pslverr <= ~hit | locked;
                if (!pwrite && hit && !locked)
                    prdata <= {24'h00_0000, ctrl_view};
            end
        end
    end

    // Level request, no edge memory: drops as soon as either input clears
    assign tick_irq = tick_flag_reg & tick_irq_enable_reg;

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        overflow |=> tick_flag_reg)
        else $error("Tick flag not set after overflow");

    AST_ACK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        (ack_wr && !overflow) |=> !tick_flag_reg)
        else $error("Acknowledge did not clear tick flag");

    AST_FLAG_RO: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_flag_reg && wr_ok && !pwdata[`PTT_ACK_BIT]) |=> tick_flag_reg)
        else $error("Write without acknowledge cleared tick flag");

    AST_ACK_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit && !locked) |=> (pslverr == 1'b0 && prdata[`PTT_ACK_BIT] == 1'b0
        && prdata[`PTT_FLAG_BIT] == $past(tick_flag_reg)))
        else $error("Control read returned wrong acknowledge or flag bit");

    AST_HOLD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick_run_enable_reg && !wr_ok) |=> (cnt_reg == '0 && !overflow) [*2])
        else $error("Divider moved while run enable clear");

    AST_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_run_enable_reg && active && src_edge && !wr_ok) |=> cnt_reg == $past(cnt_next))
        else $error("Divider did not advance on tick edge");

    AST_STOP_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !osc_run_in_stop && tick_run_enable_reg) |=> ($stable(cnt_reg) && !$rose(tick_flag_reg)))
        else $error("Divider active in stop without oscillator");

    AST_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && locked) |=> ($stable(tick_run_enable_reg) && $stable(tick_irq_enable_reg)
        && $stable(tick_rate_select_reg)))
        else $error("Control changed during low-power mode");

    AST_TICK_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow && !wr_ok) |=> ((cnt_reg & tap_low_mask) == '0 && (cnt_reg & tap_onehot) != '0))
        else $error("Tick raised away from tap midpoint");

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow && tick_irq_enable_reg && !wr_ok)
        |=> tick_irq ##1 (tick_irq || $fell(tick_flag_reg) || !tick_irq_enable_reg))
        else $error("Interrupt request not raised or dropped early");

    // A counted edge must move the divider whatever the mode
    AST_SRC_EXT: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_clock_gen_on && $stable(ext_clock_gen_on) && $rose(ext_sync_reg[1]) && tick_run_enable_reg && active)
        |=> cnt_reg == $past(cnt_next))
        else $error("External tick edge did not advance divider");

    AST_SRC_INT: assert property (@(posedge pclk) disable iff (!presetn)
        (!ext_clock_gen_on && $stable(ext_clock_gen_on) && $rose(int_sync_reg[1]) && tick_run_enable_reg && active)
        |=> cnt_reg == $past(cnt_next))
        else $error("Internal tick edge did not advance divider");

    AST_NO_EDGE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_run_enable_reg && !src_edge) |=> $stable(cnt_reg))
        else $error("Divider moved without a tick edge");

    AST_ONE_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        overflow |=> !overflow)
        else $error("Tap overflow on two cycles in a row");

    AST_FLAG_NEEDS_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        !overflow |=> !$rose(tick_flag_reg))
        else $error("Tick flag set without overflow");

    AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_flag_reg && !ack_wr) |=> tick_flag_reg)
        else $error("Tick flag cleared without acknowledge");

    AST_WAIT_RUNS: assert property (@(posedge pclk) disable iff (!presetn)
        (wait_mode && !stop_mode && tick_run_enable_reg && src_edge) |=> cnt_reg != $past(cnt_reg))
        else $error("Divider stalled in wait mode");

    AST_STOP_RUNS: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && osc_run_in_stop && tick_run_enable_reg && src_edge) |=> cnt_reg != $past(cnt_reg))
        else $error("Divider stalled in stop with oscillator on");

    AST_RUN_OFF_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_run_enable_reg && wr_ok && !pwdata[`PTT_RUN_BIT]) |=> (!tick_run_enable_reg ##1 cnt_reg == '0))
        else $error("Divider not zeroed after run cleared");

    AST_RUN_FROM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tick_run_enable_reg) |-> cnt_reg == '0)
        else $error("Divider did not restart from zero");

    AST_IE_RW: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok |=> tick_irq_enable_reg == $past(pwdata[`PTT_IE_BIT]))
        else $error("Interrupt enable not written");

    AST_RATE_RW: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok |=> tick_rate_select_reg == $past(pwdata[`PTT_RATE_MSB:`PTT_RATE_LSB]))
        else $error("Rate select not written");

    // Low-power lockout answers with an error and leaves the flag alone
    AST_LOCK_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && locked) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("Low-power access not refused");

    AST_LOCK_NO_ACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && locked) |=> !$fell(tick_flag_reg))
        else $error("Tick flag cleared during low-power mode");

endmodule

// ---- verification/ptt_tb.sv ----
`timescale 1ns/1ps
`include "ptt_regs.svh"

module tb;
    localparam int LIMIT = 90000;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic        external_clock_in = 1'b0;
    logic        internal_osc_clock = 1'b0;
    logic        ext_clock_gen_on = 1'b0;
    logic        osc_run_in_stop = 1'b0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    wire         tick_irq;
    logic [1:0]  ediv = 2'h0;
    int          cyc = 0;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          ratio [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

    ptt_timebase ptt_timebase_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_in(external_clock_in), .internal_osc_clock(internal_osc_clock),
        .ext_clock_gen_on(ext_clock_gen_on), .osc_run_in_stop(osc_run_in_stop), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .tick_irq(tick_irq));

    always #2 pclk = ~pclk;

    // Internal tick source every 2 pclk, external every 4, so the selection shows in the period
    always @(posedge pclk)
    begin
        internal_osc_clock <= ~internal_osc_clock;
        ediv               <= ediv + 2'h1;
        external_clock_in  <= ediv[1];
        cyc                <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    task automatic chkr(input int g, input int lo, input int hi);
        cmp_count++;
        if (g < lo || g > hi)
        begin
            n_errors++;
            $display("unexpected at %0t: interval %0d outside %0d..%0d", $time, g, lo, hi);
        end
    endtask

    // Master waits on pready, never assumes the zero wait states
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, `PTT_CTRL_OFFSET, {24'h000000, d}, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] d, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, {24'h000000, d});
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic wirq(output int t);
        int k;
        k = 0;
        while (tick_irq !== 1'b1 && k < 40000)
        begin
            @(posedge pclk);
            k++;
        end
        chkr(k, 0, 39999);
        t = cyc;
    endtask

    task automatic t_regs();
        rd_chk(`PTT_CTRL_OFFSET, 8'h00, 1'b0);
        wr(8'hFD);
        rd_chk(`PTT_CTRL_OFFSET, 8'h74, 1'b0);
        rd_chk(12'h004, 8'h00, 1'b1);
        wr(8'h00);
        $display("test regs done");
    endtask

    task automatic t_rate(input logic [2:0] r, input logic ext, input int tp);
        int t0;
        int t1;
        int t2;
        int p;
        p = ratio[r] * tp;
        ext_clock_gen_on <= ext;
        wr({1'b0, r, 4'h4});
        wr({1'b0, r, 4'h6});
        t0 = cyc;
        wirq(t1);
        chkr(t1 - t0, p / 2 - tp, p / 2 + 10);
        wr({1'b0, r, 4'hE});
        rd_chk(`PTT_CTRL_OFFSET, {1'b0, r, 4'h6}, 1'b0);
        wirq(t2);
        chkr(t2 - t1, p, p);
        wr(8'h08);
        $display("test rate %0d ext %0d done", r, ext);
    endtask

    task automatic t_mask();
        wr(8'h72);
        repeat (40) @(posedge pclk);
        chk({31'h0, tick_irq}, 32'h0);
        rd_chk(`PTT_CTRL_OFFSET, 8'hF2, 1'b0);
        wr(8'h74);
        @(posedge pclk);
        chk({31'h0, tick_irq}, 32'h1);
        wr(8'h7C);
        @(posedge pclk);
        chk({31'h0, tick_irq}, 32'h0);
        $display("test mask done");
    endtask

    task automatic t_low();
        int t;
        int n;
        wr(8'h76);
        wait_mode <= 1'b1;
        rd_chk(`PTT_CTRL_OFFSET, 8'h00, 1'b1);
        wirq(t);
        wr(8'h7E);
        wait_mode <= 1'b0;
        rd_chk(`PTT_CTRL_OFFSET, 8'hF6, 1'b0);
        wr(8'h74);
        wr(8'h7C);
        wr(8'h76);
        stop_mode <= 1'b1;
        n = 0;
        repeat (100)
        begin
            @(posedge pclk);
            if (tick_irq !== 1'b0)
                n++;
        end
        chk(n, 0);
        osc_run_in_stop <= 1'b1;
        wirq(t);
        stop_mode <= 1'b0;
        osc_run_in_stop <= 1'b0;
        wr(8'h74);
        wr(8'h7C);
        wait_mode <= 1'b1;
        repeat (40) @(posedge pclk);
        chk({31'h0, tick_irq}, 32'h0);
        wait_mode <= 1'b0;
        wr(8'h08);
        $display("test low power done");
    endtask

    // Slowest tap: only the first half period fits the cycle budget
    task automatic t_slow();
        int t0;
        int t1;
        int p;
        p = ratio[0] * 2;
        wr(8'h04);
        wr(8'h06);
        t0 = cyc;
        wirq(t1);
        chkr(t1 - t0, p / 2 - 2, p / 2 + 10);
        wr(8'h08);
        $display("test rate 0 done");
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int r = 1; r < 8; r++)
            t_rate(r[2:0], 1'b0, 2);
        t_slow();
        t_rate(3'h7, 1'b1, 4);
        t_mask();
        t_low();
        wrap_up();
    end
endmodule
